// ---- logic/mode_ctrl_pkg.sv ----
package mode_ctrl_pkg;

  // Command codes presented on cmd_code with a one-cycle cmd_valid.
  typedef enum logic [3:0] {
    CMD_NOP        = 4'h0,
    CMD_SLEEP      = 4'h1,
    CMD_WAKEUP     = 4'h2,
    CMD_SETUP      = 4'h3,
    CMD_TEST       = 4'h4,
    CMD_CONNECT    = 4'h5,
    CMD_BOND       = 4'h6,
    CMD_DISCONNECT = 4'h7,
    CMD_CFG_WRITE  = 4'h8,
    CMD_CFG_DONE   = 4'h9,
    CMD_DUMP       = 4'hA,
    CMD_RESTORE    = 4'hB,
    CMD_SEND_DATA  = 4'hC,
    CMD_BASE_WRITE = 4'hD
  } cmd_e;

  // Event codes on evt_code with a one-cycle evt_valid.
  typedef enum logic [3:0] {
    EVT_NONE          = 4'h0,
    EVT_CMD_OK        = 4'h1,
    EVT_CMD_ERROR     = 4'h2,
    EVT_LINK_UP       = 4'h3,
    EVT_CHANNEL_STATE = 4'h4,
    EVT_LINK_DOWN     = 4'h5,
    EVT_ADV_TIMEOUT   = 4'h6,
    EVT_DUMP_DATA     = 4'h7,
    EVT_DATA_REFUSED  = 4'h8
  } evt_e;

  // Operating modes, one-hot.
  typedef enum logic [3:0] {
    MODE_SETUP  = 4'b0001,
    MODE_ACTIVE = 4'b0010,
    MODE_SLEEP  = 4'b0100,
    MODE_TEST   = 4'b1000
  } mode_e;

  // Activity levels inside active mode, one-hot.
  typedef enum logic [2:0] {
    ACT_STANDBY   = 3'b001,
    ACT_ADVERTISE = 3'b010,
    ACT_CONNECTED = 3'b100
  } act_e;

  // Advertising type selected on the air.
  typedef enum logic [1:0] {
    ADV_NONE     = 2'h0,
    ADV_GENERAL  = 2'h1,
    ADV_LIMITED  = 2'h2,
    ADV_NON_DISC = 2'h3
  } adv_e;

  // Discovery walk, one-hot.
  typedef enum logic [4:0] {
    DISC_IDLE    = 5'b00001,
    DISC_PRIMARY = 5'b00010,
    DISC_CHARS   = 5'b00100,
    DISC_DESCR   = 5'b01000,
    DISC_SVC_CHG = 5'b10000
  } disc_e;

  localparam int BASE_ID_COUNT   = 5;
  localparam int BASE_ID_WIDTH   = 128;
  localparam int BASE_IDX_WIDTH  = 3;
  localparam int SHORT_ID_WIDTH  = 16;
  // Big-endian byte 13 holds the high byte of the short form.
  localparam int SHORT_ID_BYTE_HI = 13;
  localparam int SHORT_ID_BYTE_LO = 14;
  localparam int ID_BYTES         = 16;

  // Runtime state image: bit positions.
  localparam int RT_WIDTH       = 8;
  localparam int RT_BONDED      = 0;
  localparam int RT_DISC_VALID  = 1;
  localparam int RT_PEER_SVCCHG = 2;
  localparam int RT_PIPE_LSB    = 3;
  localparam int PIPE_WIDTH     = 5;

  localparam logic [RT_WIDTH-1:0] RT_RESET = 8'h00;
  localparam logic [PIPE_WIDTH-1:0] PIPE_NONE = 5'h00;

  // Advertising timeout.
  localparam int CLK_HZ        = 20_000_000;
  localparam int ADV_TIMEOUT_MS = 180_000;
  localparam int ADV_CNT_WIDTH = 32;

endpackage

// ---- logic/adv_timer.sv ----
`timescale 1ns/10ps
`default_nettype none

// Advertising window timer with a millisecond tick from a divider.
module adv_timer
  import mode_ctrl_pkg::*;
#(
  parameter int TICKS_PER_MS = CLK_HZ / 1000,
  parameter int TIMEOUT_MS   = ADV_TIMEOUT_MS
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Control
  input  wire logic run,
  output logic      expired
);

  logic [ADV_CNT_WIDTH-1:0] div_reg;
  logic [ADV_CNT_WIDTH-1:0] ms_reg;
  logic                     tick;

  assign tick = (div_reg == ADV_CNT_WIDTH'(TICKS_PER_MS - 1));

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= '0;
    end else if (!run || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_reg <= '0;
    end else if (!run) begin
      ms_reg <= '0;
    end else if (tick && !expired) begin
      ms_reg <= ms_reg + 1'b1;
    end
  end

  assign expired = run && (ms_reg >= ADV_CNT_WIDTH'(TIMEOUT_MS));

endmodule // adv_timer

`default_nettype wire

// ---- logic/radio_peripheral_mode_ctrl.sv ----
// Contract
// - Sleep command enters sleep; wakeup returns to active standby.
// - In sleep, links stay dropped; only wakeup is accepted.
// - Configuration survives sleep; no reconfiguration after wakeup.
// - Configuration committed to persistent store is locked.
// - Volatile-only configuration is lost on reset or power cycle.
// - Data exchange is refused until configuration sequence completes.
// - Five 128-bit base identifiers, each expanded by a short form.
// - Identifiers are big endian; short form sits in bytes 13 and 14.
// - Active entered on setup done, wakeup, test in test mode, or reset with stored setup.
// - Test, setup or sleep command leaves active for that mode.
// - Connect or bond starts advertising; a link moves to connected.
// - Advertise until link or timeout; a formed link outlives timeout.
// - Advertise general, limited for bond, non-discoverable if bonded.
// - Link-up event, then channel-state events as discovery updates.
// - After timeout or link loss, stay in standby until new command.
// - Discovery runs after linking only if pipe mapping is stale.
// - Discovery: primary, characteristics, descriptors, service change.
// - Bonded peer keeps discovery results until bond removed.
// - Discovery lost on reset or setup; non-bonded changing peer on drop.
// - Dump exports runtime state; restore reinstates it in active mode only.
// - Setup or test clears runtime data; sleep preserves it.
`timescale 1ns/10ps
`default_nettype none

module radio_peripheral_mode_ctrl
  import mode_ctrl_pkg::*;
#(
  parameter int ADV_TICKS_PER_MS = CLK_HZ / 1000
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  // Persistent store status, sampled after reset release
  input  wire logic                          persistent_store_valid,
  // Command port
  input  wire logic                          cmd_valid,
  input  wire mode_ctrl_pkg::cmd_e           cmd_code,
  input  wire logic                          cmd_persist,
  input  wire logic [BASE_IDX_WIDTH-1:0]     cmd_base_idx,
  input  wire logic [BASE_ID_WIDTH-1:0]      cmd_base_data,
  input  wire logic [RT_WIDTH-1:0]           cmd_rt_data,
  // Radio link status
  input  wire logic                          link_formed,
  input  wire logic                          link_lost,
  input  wire logic                          peer_has_svc_chg,
  input  wire logic                          peer_svc_changed,
  input  wire logic                          bond_removed_by_peer,
  input  wire logic                          disc_step_done,
  input  wire logic [PIPE_WIDTH-1:0]         disc_pipes,
  // Identifier lookup
  input  wire logic [BASE_IDX_WIDTH-1:0]     id_base_sel,
  input  wire logic [SHORT_ID_WIDTH-1:0]     id_short,
  output logic [BASE_ID_WIDTH-1:0]           id_full,
  // Event port
  output logic                               evt_valid,
  output mode_ctrl_pkg::evt_e                evt_code,
  output logic [RT_WIDTH-1:0]                evt_data,
  // Status
  output mode_ctrl_pkg::mode_e               mode,
  output mode_ctrl_pkg::act_e                activity,
  output mode_ctrl_pkg::adv_e                adv_type,
  output mode_ctrl_pkg::disc_e               disc_step,
  output logic                               cfg_locked,
  output logic                               data_enable
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Places a short form into big-endian bytes 13 and 14 of a base.
  function automatic logic [BASE_ID_WIDTH-1:0] expand_id(
    input logic [BASE_ID_WIDTH-1:0]  base,
    input logic [SHORT_ID_WIDTH-1:0] short_id
  );
    logic [BASE_ID_WIDTH-1:0] r;
    r = base;
    r[(ID_BYTES-1-SHORT_ID_BYTE_HI)*8 +: 8] = short_id[15:8];
    r[(ID_BYTES-1-SHORT_ID_BYTE_LO)*8 +: 8] = short_id[7:0];
    return r;
  endfunction

  function automatic logic cmd_is(input cmd_e c, input cmd_e want);
    return cmd_valid && (c == want);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  mode_e                     mode_reg;
  act_e                      act_reg;
  adv_e                      adv_reg;
  disc_e                     disc_reg;
  logic                      cfg_done_reg;
  logic                      cfg_locked_reg;
  logic                      boot_reg;
  logic [RT_WIDTH-1:0]       rt_reg;
  logic [BASE_ID_WIDTH-1:0]  base_mem [BASE_ID_COUNT];
  logic                      evt_valid_reg;
  evt_e                      evt_code_reg;
  logic [RT_WIDTH-1:0]       evt_data_reg;
  logic                      chan_pending_reg;
  logic                      adv_expired;
  logic                      cmd_ok;
  logic                      is_bonded;
  logic                      disc_needed;

  assign is_bonded = rt_reg[RT_BONDED];

  // Mapping is stale for an unknown peer or one whose services changed.
  assign disc_needed = !rt_reg[RT_DISC_VALID] || peer_svc_changed ||
                       (!is_bonded && peer_has_svc_chg);

  adv_timer #(
    .TICKS_PER_MS (ADV_TICKS_PER_MS),
    .TIMEOUT_MS   (ADV_TIMEOUT_MS)
  ) u_adv_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .run      (act_reg == ACT_ADVERTISE && mode_reg == MODE_ACTIVE),
    .expired  (adv_expired)
  );

  // ----------------------------------------------------------------
  // Command legality
  // ----------------------------------------------------------------

  always_comb begin
    cmd_ok = 1'b0;
    unique case (mode_reg)
      MODE_SLEEP:  cmd_ok = (cmd_code == CMD_WAKEUP);
      MODE_SETUP:  cmd_ok = (cmd_code == CMD_CFG_WRITE && !cfg_locked_reg) ||
                            (cmd_code == CMD_BASE_WRITE && !cfg_locked_reg) ||
                            (cmd_code == CMD_CFG_DONE) ||
                            (cmd_code == CMD_TEST) ||
                            (cmd_code == CMD_SETUP);
      MODE_TEST:   cmd_ok = (cmd_code == CMD_TEST) ||
                            (cmd_code == CMD_SETUP);
      MODE_ACTIVE: cmd_ok = (cmd_code != CMD_WAKEUP) &&
                            (cmd_code != CMD_CFG_WRITE) &&
                            (cmd_code != CMD_CFG_DONE) &&
                            (cmd_code != CMD_BASE_WRITE) &&
                            (cmd_code != CMD_NOP) &&
                            !(cmd_code == CMD_SEND_DATA &&
                              act_reg != ACT_CONNECTED) &&
                            !((cmd_code == CMD_CONNECT ||
                               cmd_code == CMD_BOND) &&
                              act_reg != ACT_STANDBY);
    endcase
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= MODE_SETUP;
      boot_reg <= 1'b1;
    end else if (boot_reg) begin
      boot_reg <= 1'b0;
      if (persistent_store_valid) begin
        mode_reg <= MODE_ACTIVE;
      end
    end else if (cmd_valid && cmd_ok) begin
      unique case (cmd_code)
        CMD_SLEEP:    mode_reg <= MODE_SLEEP;
        CMD_WAKEUP:   mode_reg <= MODE_ACTIVE;
        CMD_SETUP:    mode_reg <= MODE_SETUP;
        CMD_TEST:     mode_reg <= (mode_reg == MODE_TEST) ?
                                  MODE_ACTIVE : MODE_TEST;
        CMD_CFG_DONE: mode_reg <= MODE_ACTIVE;
        default:      mode_reg <= mode_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------

  // Volatile configuration is only flops, so reset drops it; a valid
  // persistent store restores the done and locked state at boot.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_done_reg   <= 1'b0;
      cfg_locked_reg <= 1'b0;
    end else if (boot_reg) begin
      cfg_done_reg   <= persistent_store_valid;
      cfg_locked_reg <= persistent_store_valid;
    end else if (cmd_valid && cmd_ok) begin
      if (cmd_code == CMD_CFG_WRITE) begin
        cfg_done_reg <= 1'b0;
      end else if (cmd_code == CMD_CFG_DONE) begin
        cfg_done_reg <= 1'b1;
        if (cmd_persist) begin
          cfg_locked_reg <= 1'b1;
        end
      end
    end
  end

  // Base identifiers keep their values through sleep.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BASE_ID_COUNT; i++) begin
        base_mem[i] <= '0;
      end
    end else if (cmd_is(cmd_code, CMD_BASE_WRITE) && cmd_ok &&
                 cmd_base_idx < BASE_IDX_WIDTH'(BASE_ID_COUNT)) begin
      base_mem[cmd_base_idx] <= cmd_base_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      id_full <= '0;
    end else if (id_base_sel < BASE_IDX_WIDTH'(BASE_ID_COUNT)) begin
      id_full <= expand_id(base_mem[id_base_sel], id_short);
    end else begin
      id_full <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Activity inside active mode
  // ----------------------------------------------------------------

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_reg <= ACT_STANDBY;
      adv_reg <= ADV_NONE;
    end else if (mode_reg != MODE_ACTIVE) begin
      act_reg <= ACT_STANDBY;
      adv_reg <= ADV_NONE;
    end else begin
      unique case (act_reg)
        ACT_STANDBY: begin
          if (cmd_valid && cmd_ok &&
              (cmd_code == CMD_CONNECT || cmd_code == CMD_BOND)) begin
            act_reg <= ACT_ADVERTISE;
            if (cmd_code == CMD_BOND) begin
              adv_reg <= ADV_LIMITED;
            end else if (is_bonded) begin
              adv_reg <= ADV_NON_DISC;
            end else begin
              adv_reg <= ADV_GENERAL;
            end
          end
        end
        ACT_ADVERTISE: begin
          if (link_formed) begin
            act_reg <= ACT_CONNECTED;
            adv_reg <= ADV_NONE;
          end else if (adv_expired || cmd_is(cmd_code, CMD_DISCONNECT)) begin
            act_reg <= ACT_STANDBY;
            adv_reg <= ADV_NONE;
          end
        end
        ACT_CONNECTED: begin
          if (link_lost || cmd_is(cmd_code, CMD_DISCONNECT)) begin
            act_reg <= ACT_STANDBY;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Discovery walk
  // ----------------------------------------------------------------

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      disc_reg <= DISC_IDLE;
    end else if (act_reg != ACT_CONNECTED || mode_reg != MODE_ACTIVE) begin
      disc_reg <= DISC_IDLE;
    end else begin
      unique case (disc_reg)
        DISC_IDLE:
          if ((act_reg == ACT_CONNECTED && chan_pending_reg && disc_needed) ||
              peer_svc_changed) begin
            disc_reg <= DISC_PRIMARY;
          end
        DISC_PRIMARY: if (disc_step_done) disc_reg <= DISC_CHARS;
        DISC_CHARS:   if (disc_step_done) disc_reg <= DISC_DESCR;
        DISC_DESCR:   if (disc_step_done) disc_reg <= DISC_SVC_CHG;
        DISC_SVC_CHG: if (disc_step_done) disc_reg <= DISC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Runtime state: bond, discovery associations, pipes
  // ----------------------------------------------------------------

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rt_reg <= RT_RESET;
    end else if (cmd_valid && cmd_ok &&
                 (cmd_code == CMD_SETUP || cmd_code == CMD_TEST)) begin
      rt_reg <= RT_RESET;
    end else if (cmd_is(cmd_code, CMD_RESTORE) && cmd_ok) begin
      rt_reg <= cmd_rt_data;
    end else if (cmd_is(cmd_code, CMD_BOND) && cmd_ok) begin
      rt_reg <= RT_RESET;
    end else if (bond_removed_by_peer) begin
      rt_reg <= RT_RESET;
    end else if (act_reg == ACT_CONNECTED &&
                 (link_lost || cmd_is(cmd_code, CMD_DISCONNECT))) begin
      if (!is_bonded && rt_reg[RT_PEER_SVCCHG]) begin
        rt_reg[RT_DISC_VALID] <= 1'b0;
      end
      rt_reg[RT_PIPE_LSB +: PIPE_WIDTH] <= PIPE_NONE;
    end else if (act_reg == ACT_ADVERTISE && link_formed &&
                 adv_reg == ADV_LIMITED) begin
      rt_reg[RT_BONDED]      <= 1'b1;
      rt_reg[RT_PEER_SVCCHG] <= peer_has_svc_chg;
    end else if (disc_reg == DISC_SVC_CHG && disc_step_done) begin
      rt_reg[RT_DISC_VALID]              <= 1'b1;
      rt_reg[RT_PEER_SVCCHG]             <= peer_has_svc_chg;
      rt_reg[RT_PIPE_LSB +: PIPE_WIDTH]  <= disc_pipes;
    end
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------

  // A pending channel-state report is sent in the cycle after link-up.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_valid_reg    <= 1'b0;
      evt_code_reg     <= EVT_NONE;
      evt_data_reg     <= '0;
      chan_pending_reg <= 1'b0;
    end else begin
      evt_valid_reg <= 1'b0;
      evt_data_reg  <= '0;
      if (mode_reg == MODE_ACTIVE && act_reg == ACT_ADVERTISE &&
          link_formed) begin
        evt_valid_reg    <= 1'b1;
        evt_code_reg     <= EVT_LINK_UP;
        chan_pending_reg <= 1'b1;
      end else if (chan_pending_reg ||
                   (disc_reg != DISC_IDLE && disc_step_done)) begin
        evt_valid_reg    <= 1'b1;
        evt_code_reg     <= EVT_CHANNEL_STATE;
        evt_data_reg     <= {3'b000, rt_reg[RT_PIPE_LSB +: PIPE_WIDTH]};
        chan_pending_reg <= 1'b0;
      end else if (mode_reg == MODE_ACTIVE && act_reg == ACT_CONNECTED &&
                   link_lost) begin
        evt_valid_reg <= 1'b1;
        evt_code_reg  <= EVT_LINK_DOWN;
      end else if (mode_reg == MODE_ACTIVE && adv_expired &&
                   act_reg == ACT_ADVERTISE) begin
        evt_valid_reg <= 1'b1;
        evt_code_reg  <= EVT_ADV_TIMEOUT;
      end else if (cmd_valid && !boot_reg) begin
        evt_valid_reg <= 1'b1;
        if (cmd_code == CMD_SEND_DATA && !cfg_done_reg) begin
          evt_code_reg <= EVT_DATA_REFUSED;
        end else if (!cmd_ok) begin
          evt_code_reg <= EVT_CMD_ERROR;
        end else if (cmd_code == CMD_DUMP) begin
          evt_code_reg <= EVT_DUMP_DATA;
          evt_data_reg <= rt_reg;
        end else begin
          evt_code_reg <= EVT_CMD_OK;
        end
      end
    end
  end

  assign evt_valid   = evt_valid_reg;
  assign evt_code    = evt_code_reg;
  assign evt_data    = evt_data_reg;
  assign mode        = mode_reg;
  assign activity    = act_reg;
  assign adv_type    = adv_reg;
  assign disc_step   = disc_reg;
  assign cfg_locked  = cfg_locked_reg;
  // Data only flows once setup is complete and a link is up.
  assign data_enable = cfg_done_reg && mode_reg == MODE_ACTIVE &&
                       act_reg == ACT_CONNECTED;

endmodule // radio_peripheral_mode_ctrl

`default_nettype wire

// ---- verification/mode_ctrl_props.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Mode controller checker
// ----------------------------------------
module mode_ctrl_props
  import mode_ctrl_pkg::*;
(
  // Clock, reset and inputs
  input wire logic                      core_clk,
  input wire logic                      rst_b,
  input wire logic                      cmd_valid,
  input wire mode_ctrl_pkg::cmd_e       cmd_code,
  input wire logic                      link_formed,
  input wire logic                      disc_step_done,
  input wire logic [SHORT_ID_WIDTH-1:0] id_short,
  // Outputs
  input wire logic [BASE_ID_WIDTH-1:0]  id_full,
  input wire logic                      evt_valid,
  input wire mode_ctrl_pkg::evt_e       evt_code,
  input wire mode_ctrl_pkg::mode_e      mode,
  input wire mode_ctrl_pkg::act_e       activity,
  input wire mode_ctrl_pkg::adv_e       adv_type,
  input wire mode_ctrl_pkg::disc_e      disc_step,
  input wire logic                      cfg_locked,
  input wire logic                      data_enable
);
  import mode_ctrl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence link_up_seq;
    activity == ACT_CONNECTED && evt_valid && evt_code == EVT_LINK_UP
    ##1 evt_valid && evt_code == EVT_CHANNEL_STATE;
  endsequence
  a_sleep_entry: assert property (cmd_valid && cmd_code == CMD_SLEEP &&
    mode == MODE_ACTIVE && activity == ACT_STANDBY |=> mode == MODE_SLEEP)
    else $error("sleep not entered");
  a_wake_standby: assert property (mode == MODE_SLEEP && cmd_valid &&
    cmd_code == CMD_WAKEUP |=> mode == MODE_ACTIVE && activity == ACT_STANDBY)
    else $error("wakeup did not reach standby");
  a_sleep_refuse: assert property (mode == MODE_SLEEP && cmd_valid &&
    cmd_code != CMD_WAKEUP |=> evt_code == EVT_CMD_ERROR && mode == MODE_SLEEP)
    else $error("sleep accepted a command");
  a_sleep_idle: assert property (mode == MODE_SLEEP |->
    activity == ACT_STANDBY && !data_enable) else $error("sleep not idle");
  a_data_refused: assert property (mode == MODE_SETUP && cmd_valid &&
    cmd_code == CMD_SEND_DATA |-> !data_enable ##1
    evt_valid && evt_code == EVT_DATA_REFUSED) else $error("data not refused");
  a_locked_write: assert property (cfg_locked && cmd_valid &&
    cmd_code == CMD_CFG_WRITE |=> evt_code == EVT_CMD_ERROR && cfg_locked)
    else $error("locked config rewritten");
  a_bond_limited: assert property (mode == MODE_ACTIVE && cmd_valid &&
    activity == ACT_STANDBY && cmd_code == CMD_BOND |=>
    activity == ACT_ADVERTISE && adv_type == ADV_LIMITED)
    else $error("bond advertising wrong");
  a_link_events: assert property (activity == ACT_ADVERTISE &&
    link_formed |=> link_up_seq) else $error("link events wrong");
  a_disc_walk: assert property (disc_step != DISC_IDLE && disc_step_done
    |=> disc_step == {$past(disc_step[3:0]), $past(disc_step[4])})
    else $error("discovery step order wrong");
  a_setup_entry: assert property (mode == MODE_ACTIVE && cmd_valid &&
    cmd_code == CMD_SETUP |=> mode == MODE_SETUP) else $error("no setup");
  a_short_place: assert property (1'b1 |=>
    id_full[23:8] == $past(id_short)) else $error("short id misplaced");
endmodule // mode_ctrl_props
bind radio_peripheral_mode_ctrl mode_ctrl_props u_props (.core_clk, .rst_b,
  .cmd_valid, .cmd_code, .link_formed, .disc_step_done, .id_short, .id_full,
  .evt_valid, .evt_code, .mode, .activity, .adv_type, .disc_step,
  .cfg_locked, .data_enable);
`default_nettype wire

// ---- verification/peer_radio_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Remote central: links and answers discovery
// ----------------------------------------
module peer_radio_model (
  // Clock and control
  input wire logic core_clk,
  input wire logic accept,
  input wire logic adv_on,
  input wire logic disc_busy,
  // Radio pulses
  output logic     link_formed,
  output logic     disc_step_done
);
  logic [2:0] cnt_reg = 3'h0;
  initial link_formed = 1'b0;
  initial disc_step_done = 1'b0;
  // A free counter gives both prompt and slow answers.
  always @(negedge core_clk) begin
    cnt_reg <= cnt_reg + 3'h1;
    link_formed <= accept && adv_on && !link_formed && cnt_reg == 3'h7;
    disc_step_done <= disc_busy && !disc_step_done && cnt_reg[0];
  end
endmodule // peer_radio_model
`default_nettype wire

// ---- verification/radio_peripheral_mode_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module radio_peripheral_mode_ctrl_tb;
  import mode_ctrl_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0, pv = 1'b0, cmd_valid = 1'b0;
  logic cmd_persist = 1'b0, accept = 1'b0, link_formed, step_done;
  cmd_e cmd_code = CMD_NOP;
  logic [2:0] cmd_base_idx = 3'h0, id_base_sel = 3'h0;
  logic [127:0] cmd_base_data = '0, id_full, bases [BASE_ID_COUNT];
  logic [7:0] cmd_rt_data = 8'h00, evt_data, rt;
  logic [4:0] disc_pipes = 5'h00;
  logic [15:0] id_short = 16'h0000;
  logic evt_valid, cfg_locked, data_enable;
  evt_e evt_code; mode_e mode; act_e activity;
  adv_e adv_type; disc_e disc_step;
  logic [31:0] seed = 32'h0c47_1f66;
  int mismatches = 0, n_checks = 0;
  always #25 core_clk = ~core_clk;
  radio_peripheral_mode_ctrl #(.ADV_TICKS_PER_MS(1)) dut (.core_clk, .rst_b,
    .persistent_store_valid(pv), .cmd_valid, .cmd_code, .cmd_persist,
    .cmd_base_idx, .cmd_base_data, .cmd_rt_data, .link_formed,
    .link_lost(1'b0), .peer_has_svc_chg(1'b0), .peer_svc_changed(1'b0),
    .bond_removed_by_peer(1'b0), .disc_step_done(step_done), .disc_pipes,
    .id_base_sel, .id_short, .id_full, .evt_valid, .evt_code, .evt_data,
    .mode, .activity, .adv_type, .disc_step, .cfg_locked, .data_enable);
  peer_radio_model peer (.core_clk, .accept, .adv_on(activity == ACT_ADVERTISE),
    .disc_busy(disc_step != DISC_IDLE), .link_formed,
    .disc_step_done(step_done));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'ha300_0000 : 32'h0000_0000);
  endfunction
  function automatic logic [127:0] expand(input logic [127:0] b,
                                          input logic [15:0] s);
    expand = b;
    expand[8*(ID_BYTES-SHORT_ID_BYTE_HI)-1 -: 16] = s;
  endfunction
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_evt(input evt_e e);
    chk({evt_valid, evt_code}, {1'b1, e});
  endtask
  task automatic cmd(input cmd_e c, input logic [7:0] d);
    @(negedge core_clk);
    cmd_valid = 1'b1; cmd_code = c; cmd_rt_data = d;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic do_reset(input logic v);
    rst_b = 1'b0; pv = v;
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic conclude;
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    mismatches++;
    conclude;
  end
  initial begin
    do_reset(1'b0);
    chk(mode, MODE_SETUP);
    cmd(CMD_SEND_DATA, 8'h00); chk_evt(EVT_DATA_REFUSED);
    for (int i = 0; i < BASE_ID_COUNT; i++) begin
      seed = lfsr(seed);
      bases[i] = {seed, lfsr(seed), ~seed, seed ^ 32'h5a5a_5a5a};
      cmd_base_idx = 3'(i); cmd_base_data = bases[i];
      cmd(CMD_BASE_WRITE, 8'h00); chk_evt(EVT_CMD_OK);
    end
    cmd(CMD_CFG_DONE, 8'h00); chk(mode, MODE_ACTIVE);
    for (int i = 0; i < BASE_ID_COUNT; i++) begin
      seed = lfsr(seed); id_base_sel = 3'(i); id_short = seed[15:0];
      @(negedge core_clk);
      chk(id_full, expand(bases[i], seed[15:0]));
    end
    disc_pipes = seed[20:16]; accept = 1'b1;
    cmd(CMD_BOND, 8'h00); chk(adv_type, ADV_LIMITED);
    for (int i = 0; i < 40 && evt_code !== EVT_LINK_UP; i++)
      @(negedge core_clk);
    chk(activity, ACT_CONNECTED);
    chk(data_enable, 1'b1);
    @(negedge core_clk); chk_evt(EVT_CHANNEL_STATE);
    chk(disc_step, DISC_PRIMARY);
    accept = 1'b0;
    for (int i = 0; i < 60 && disc_step !== DISC_IDLE; i++)
      @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    cmd(CMD_DUMP, 8'h00); chk(evt_data, {disc_pipes, 3'b011});
    cmd(CMD_DISCONNECT, 8'h00); chk(activity, ACT_STANDBY);
    repeat (3) @(negedge core_clk);
    seed = lfsr(seed); rt = seed[7:0];
    cmd(CMD_RESTORE, rt); chk_evt(EVT_CMD_OK);
    cmd(CMD_SLEEP, 8'h00); chk(mode, MODE_SLEEP);
    cmd(cmd_e'(4'(seed[31:8] % 7) + 4'h5), 8'h00);
    chk_evt(EVT_CMD_ERROR);
    cmd(CMD_WAKEUP, 8'h00); chk(activity, ACT_STANDBY);
    cmd(CMD_DUMP, 8'h00); chk(evt_data, rt);
    cmd(CMD_CONNECT, 8'h00);
    chk(adv_type, rt[RT_BONDED] ? ADV_NON_DISC : ADV_GENERAL);
    cmd(CMD_SETUP, 8'h00); chk(mode, MODE_SETUP);
    cmd_persist = 1'b1;
    cmd(CMD_CFG_DONE, 8'h00); chk(cfg_locked, 1'b1);
    cmd(CMD_DUMP, 8'h00); chk(evt_data, RT_RESET);
    cmd(CMD_SETUP, 8'h00);
    cmd(CMD_CFG_WRITE, 8'h00); chk_evt(EVT_CMD_ERROR);
    do_reset(1'b0); chk(mode, MODE_SETUP);
    do_reset(1'b1); chk(mode, MODE_ACTIVE);
    cmd(CMD_TEST, 8'h00); chk(mode, MODE_TEST);
    conclude;
  end
endmodule // radio_peripheral_mode_ctrl_tb
`default_nettype wire
